// file: verilog/sfnc_convert.sv
// How it works
// - 11-bit float: 5-bit exponent, 6-bit mantissa
// - 11-bit code splits at 64
// - 11-bit decode: zero, denormal, normal, Inf/NaN
// - 11-bit encode rounds nearest, truncation optional
// - 11-bit encode: negatives zero, saturate 65024
// - Encoders: -Inf zero, +Inf kept, NaN positive
// - 10-bit float: 5-bit exponent, 5-bit mantissa
// - 10-bit code splits at 32
// - 10-bit decode: zero, denormal, normal, Inf/NaN
// - 10-bit encode rounds nearest, truncation optional
// - 10-bit encode: negatives zero, saturate 64512
// - Denormals predictable; specials never stall
// - Fixed vertex format is signed 16.16
// - Normalized width at least two
// - Unsigned normalized to float: c/(2^b-1)
// - Signed normalized to float, clamped at -1
// - Float to unsigned normalized, clamp, round
// - Float to signed normalized, clamp, round
// - One signed equation used for all users
`timescale 1ns/1ps
`default_nettype none
`include "sfnc_cfg.svh"

module sfnc_convert
  import sfnc_pkg::*;
#(
  parameter int NORM_BITS = `SFNC_NORM_BITS_DEF
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic valid_in,
  input wire logic [3:0] op_in,
  input wire logic round_zero_in,
  input wire logic [31:0] data_in,
  output logic valid_out,
  output logic [31:0] result_out
);

  // ****************************************
  // Parameter check
  // ****************************************
  if (NORM_BITS < `SFNC_NORM_BITS_MIN || NORM_BITS > `SFNC_NORM_BITS_MAX) begin : g_bad_b
    $error("NORM_BITS out of range");
  end

  localparam int DMIN = 1 - `SFNC_SMALL_BIAS;

  // ****************************************
  // Small float decode to binary32
  // ****************************************
  function automatic logic [31:0] dec_small(input logic [4:0] e, input logic [5:0] m6);
    int p;
    p = 0;
    if (e == `SFNC_SMALL_EMAX) begin
      return (m6 == 6'h00) ? `SFNC_F32_INF : `SFNC_F32_NAN;
    end
    if (e != 5'h00) begin
      return {1'b0, 8'(e) + 8'(`SFNC_F32_BIAS - `SFNC_SMALL_BIAS), m6, 17'h00000};
    end
    if (m6 == 6'h00) begin
      return 32'h00000000;
    end
    // Denormal: renormalise around the leading one
    for (int i = 0; i < `SFNC_M11_BITS; i++) begin
      if (m6[i]) begin
        p = i;
      end
    end
    return {1'b0, 8'(p + `SFNC_F32_BIAS + DMIN - `SFNC_M11_BITS),
            23'({m6, 17'h00000} << (`SFNC_M11_BITS - p))};
  endfunction : dec_small

  // ****************************************
  // Binary32 encode to small float
  // ****************************************
  function automatic logic [10:0] enc_small(input logic [31:0] f, input int mw,
                                            input logic rz);
    int ue;
    int sh;
    logic [24:0] sig;
    logic [24:0] q;
    logic [11:0] code;
    logic [11:0] maxc;
    maxc = 12'((32'(`SFNC_SMALL_EMAX) << mw) - 1);
    ue = int'(f[30:23]) - `SFNC_F32_BIAS;
    sig = {2'b01, f[22:0]};
    if (f[30:23] == `SFNC_F32_EMAX) begin
      if (f[22:0] != 23'h000000) begin
        return 11'((32'(`SFNC_SMALL_EMAX) << mw) | (32'h1 << (mw - 1)));
      end
      return f[31] ? 11'h000 : 11'(32'(`SFNC_SMALL_EMAX) << mw);
    end
    if (f[31] || f[30:23] == 8'h00) begin
      return 11'h000;
    end
    if (ue > `SFNC_SMALL_BIAS) begin
      return 11'(maxc);
    end
    sh = 23 - mw + ((ue < DMIN) ? (DMIN - ue) : 0);
    if (sh > 24) begin
      return 11'h000;
    end
    q = sig >> sh;
    if (!rz && sig[sh-1]) begin
      q = q + 25'h0000001;
    end
    // Rounding carry walks into the exponent field on its own
    code = 12'(q) + ((ue >= DMIN) ? 12'((ue - DMIN) << mw) : 12'h000);
    return 11'((code > maxc) ? maxc : code);
  endfunction : enc_small

  // ****************************************
  // Fixed magnitude to binary32
  // ****************************************
  function automatic logic [31:0] to_f(input logic s, input logic [47:0] mag, input int scale);
    int p;
    logic [47:0] t;
    p = 0;
    if (mag == 48'h000000000000) begin
      return 32'h00000000;
    end
    for (int i = 0; i < 48; i++) begin
      if (mag[i]) begin
        p = i;
      end
    end
    t = mag << (47 - p);
    return {s, 8'(p - scale + `SFNC_F32_BIAS), t[46:24]};
  endfunction : to_f

  // Repeating pattern equals c/(2^w-1) without a divider
  function automatic logic [47:0] rep(input logic [15:0] c, input int w);
    logic [47:0] r;
    r = 48'h000000000000;
    for (int i = 0; i < 48; i++) begin
      r[47-i] = c[w - 1 - (i % w)];
    end
    return r;
  endfunction : rep

  // ****************************************
  // Binary32 magnitude to scaled integer
  // ****************************************
  function automatic logic [15:0] f2n(input logic [31:0] f, input int w);
    int ue;
    logic [63:0] fx;
    logic [63:0] r;
    ue = int'(f[30:23]) - `SFNC_F32_BIAS;
    if (f[30:23] == `SFNC_F32_EMAX && f[22:0] != 23'h000000) begin
      return 16'h0000;
    end
    if (ue >= 0) begin
      return 16'((32'h1 << w) - 1);
    end
    if (ue < -`SFNC_SCALE_FRAC - 1 || f[30:23] == 8'h00) begin
      return 16'h0000;
    end
    fx = {40'h0000000000, 1'b1, f[22:0]};
    if (ue + 32 - 23 >= 0) begin
      fx = fx << (ue + 32 - 23);
    end else begin
      fx = fx >> (23 - 32 - ue);
    end
    r = (fx << w) - fx;
    r = r + (64'h1 << (`SFNC_SCALE_FRAC - 1));
    return 16'(r >> `SFNC_SCALE_FRAC);
  endfunction : f2n

  // ****************************************
  // Input stage
  // ****************************************
  logic v1_r;
  sfnc_op_t op1_r;
  logic rz1_r;
  logic [31:0] d1_r;

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      v1_r <= 1'b0;
      op1_r <= SFNC_OP_DEC11;
      rz1_r <= 1'b0;
      d1_r <= 32'h00000000;
    end else begin
      v1_r <= valid_in;
      op1_r <= sfnc_op_t'(op_in);
      rz1_r <= round_zero_in;
      d1_r <= data_in;
    end
  end

  // ****************************************
  // Operation datapath
  // ****************************************
  logic [31:0] res_nxt;
  logic [15:0] nc;
  logic [15:0] nmag;
  logic [15:0] nmax;
  logic nneg;
  logic [31:0] fmag;

  always_comb begin
    nc = 16'(d1_r[NORM_BITS-1:0]);
    nneg = d1_r[NORM_BITS-1];
    nmax = 16'((32'h1 << (NORM_BITS - 1)) - 1);
    nmag = nneg ? 16'(16'h0000 - 16'(signed'(d1_r[NORM_BITS-1:0]))) : nc;
    fmag = d1_r[31] ? 32'h00000000 - d1_r : d1_r;
    res_nxt = 32'h00000000;
    case (op1_r)
      SFNC_OP_DEC11: res_nxt = dec_small(d1_r[10:6], d1_r[5:0]);
      SFNC_OP_DEC10: res_nxt = dec_small(d1_r[9:5], {d1_r[4:0], 1'b0});
      SFNC_OP_ENC11: begin
        res_nxt = {21'h000000, enc_small(d1_r, `SFNC_M11_BITS, rz1_r)};
      end
      SFNC_OP_ENC10: begin
        res_nxt = {21'h000000, enc_small(d1_r, `SFNC_M10_BITS, rz1_r)};
      end
      SFNC_OP_UN2F: begin
        if (nc == 16'((32'h1 << NORM_BITS) - 1)) begin
          res_nxt = `SFNC_F32_ONE;
        end else begin
          res_nxt = to_f(1'b0, rep(nc, NORM_BITS), 48);
        end
      end
      SFNC_OP_SN2F: begin
        if (nmag >= nmax) begin
          res_nxt = nneg ? `SFNC_F32_MONE : `SFNC_F32_ONE;
        end else begin
          res_nxt = to_f(nneg, rep(nmag, NORM_BITS - 1), 48);
        end
      end
      SFNC_OP_F2UN: begin
        res_nxt = d1_r[31] ? 32'h00000000 : {16'h0000, f2n(d1_r, NORM_BITS)};
      end
      SFNC_OP_F2SN: begin
        nmag = f2n(d1_r, NORM_BITS - 1);
        res_nxt = d1_r[31] ? 32'h00000000 - {16'h0000, nmag} : {16'h0000, nmag};
      end
      SFNC_OP_FX2F: res_nxt = to_f(d1_r[31], {16'h0000, fmag}, `SFNC_FIX_FRAC);
      default: res_nxt = 32'h00000000;
    endcase
  end

  // ****************************************
  // Output stage
  // ****************************************
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      valid_out <= 1'b0;
      result_out <= 32'h00000000;
    end else begin
      valid_out <= v1_r;
      result_out <= res_nxt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!nrst_in);

  logic op_dec11;
  logic op_dec10;
  logic op_enc11;
  logic op_enc10;
  logic f_nan;
  logic f_pos_big;
  assign op_dec11 = valid_in && op_in == SFNC_OP_DEC11;
  assign op_dec10 = valid_in && op_in == SFNC_OP_DEC10;
  assign op_enc11 = valid_in && op_in == SFNC_OP_ENC11;
  assign op_enc10 = valid_in && op_in == SFNC_OP_ENC10;
  assign f_nan = data_in[30:23] == `SFNC_F32_EMAX && data_in[22:0] != 23'h000000;
  assign f_pos_big = !data_in[31] && data_in[30:23] != `SFNC_F32_EMAX
                     && data_in[30:23] > 8'(`SFNC_F32_BIAS + `SFNC_SMALL_BIAS);

  a_fixed_latency: assert property (
    valid_in |-> ##2 valid_out)
    else $error("valid latency not two");
  a_no_spurious_valid: assert property (
    !valid_in |-> ##2 !valid_out)
    else $error("valid without operand");
  a_dec11_inf: assert property (
    op_dec11 && data_in[10:0] == `SFNC_INF11 |-> ##2 valid_out && result_out == `SFNC_F32_INF)
    else $error("11-bit Inf decode wrong");
  a_dec11_one: assert property (
    op_dec11 && data_in[10:0] == 11'h3C0 |-> ##2 result_out == `SFNC_F32_ONE)
    else $error("11-bit one decode wrong");
  a_dec10_nan: assert property (
    op_dec10 && data_in[9:5] == `SFNC_SMALL_EMAX && data_in[4:0] != 5'h00
    |-> ##2 result_out == `SFNC_F32_NAN)
    else $error("10-bit NaN decode wrong");
  a_dec10_one: assert property (
    op_dec10 && data_in[9:0] == 10'h1E0 |-> ##2 result_out == `SFNC_F32_ONE)
    else $error("10-bit one decode wrong");
  a_enc11_neg: assert property (
    op_enc11 && data_in[31] && !f_nan |-> ##2 result_out == 32'h00000000)
    else $error("negative 11-bit encode not zero");
  a_enc11_sat: assert property (
    op_enc11 && f_pos_big |-> ##2 result_out[10:0] == `SFNC_MAX11)
    else $error("11-bit encode not saturated");
  a_enc10_sat: assert property (
    op_enc10 && f_pos_big |-> ##2 result_out[9:0] == `SFNC_MAX10)
    else $error("10-bit encode not saturated");
  a_enc_nan_pos: assert property (
    (op_enc11 || op_enc10) && f_nan |-> ##2 result_out[10:0] ==
      (($past(op_in, 2) == SFNC_OP_ENC11) ? `SFNC_NAN11 : 11'(`SFNC_NAN10)))
    else $error("NaN encode not positive NaN");
  a_enc11_one: assert property (
    op_enc11 && data_in == `SFNC_F32_ONE |-> ##2 result_out[10:0] == 11'h3C0)
    else $error("11-bit one encode wrong");
  a_sn2f_clamp: assert property (
    valid_in && op_in == SFNC_OP_SN2F
    && data_in[NORM_BITS-1:0] == {1'b1, {(NORM_BITS - 1){1'b0}}}
    |-> ##2 result_out == `SFNC_F32_MONE)
    else $error("most negative code not clamped");
  a_f2un_clamp: assert property (
    valid_in && op_in == SFNC_OP_F2UN && !data_in[31] && !f_nan
    && data_in[30:23] >= 8'(`SFNC_F32_BIAS)
    |-> ##2 result_out == 32'((32'h1 << NORM_BITS) - 1))
    else $error("unsigned clamp at one wrong");
  a_f2sn_clamp: assert property (
    valid_in && op_in == SFNC_OP_F2SN && data_in[31] && !f_nan
    && data_in[30:23] >= 8'(`SFNC_F32_BIAS)
    |-> ##2 result_out == 32'h00000000 - 32'((32'h1 << (NORM_BITS - 1)) - 1))
    else $error("signed clamp at minus one wrong");

  c_enc11_denorm: cover property (op_enc11 && data_in[30:23] == 8'h70 ##2 valid_out);
  c_dec10_denorm: cover property (op_dec10 && data_in[9:5] == 5'h00 && data_in[4:0] != 5'h00);
  c_back_to_back: cover property (valid_in [*4]);
  c_fx2f: cover property (valid_in && op_in == SFNC_OP_FX2F && data_in[31]);

endmodule : sfnc_convert

`default_nettype wire

// file: verilog/sfnc_cfg.svh
`ifndef SFNC_CFG_SVH
`define SFNC_CFG_SVH

// ****************************************
// Binary32 carrier constants
// ****************************************
`define SFNC_F32_BIAS 127
`define SFNC_F32_EMAX 8'hFF
`define SFNC_F32_INF 32'h7F800000
`define SFNC_F32_NAN 32'h7FC00000
`define SFNC_F32_ONE 32'h3F800000
`define SFNC_F32_MONE 32'hBF800000

// ****************************************
// Small float layout
// ****************************************
`define SFNC_SMALL_BIAS 15
`define SFNC_SMALL_EMAX 5'h1F
`define SFNC_M11_BITS 6
`define SFNC_M10_BITS 5
`define SFNC_INF11 11'h7C0
`define SFNC_INF10 10'h3E0
`define SFNC_MAX11 11'h7BF
`define SFNC_MAX10 10'h3DF
`define SFNC_NAN11 11'h7E0
`define SFNC_NAN10 10'h3F0

// ****************************************
// Fixed point and normalized widths
// ****************************************
`define SFNC_FIX_FRAC 16
`define SFNC_NORM_BITS_DEF 8
`define SFNC_NORM_BITS_MIN 2
`define SFNC_NORM_BITS_MAX 16
`define SFNC_SCALE_FRAC 32

`endif

// file: verilog/sfnc_pkg.sv
package sfnc_pkg;

  // ****************************************
  // Operation select
  // ****************************************
  typedef enum logic [3:0] {
    SFNC_OP_DEC11,
    SFNC_OP_DEC10,
    SFNC_OP_ENC11,
    SFNC_OP_ENC10,
    SFNC_OP_UN2F,
    SFNC_OP_SN2F,
    SFNC_OP_F2UN,
    SFNC_OP_F2SN,
    SFNC_OP_FX2F
  } sfnc_op_t;

endpackage : sfnc_pkg

// file: tb/test_small_float_norm_convert.sv
`timescale 1ns/1ps
`default_nettype none

module test_small_float_norm_convert
  import sfnc_pkg::*;
;
  // ****************************************
  // Stimulus and observation
  // ****************************************
  logic clock_in = 1'b0;
  logic nrst_in = 1'b0;
  logic valid_in = 1'b0;
  logic [3:0] op_in = 4'h0;
  logic round_zero_in = 1'b0;
  logic [31:0] data_in = 32'h0;
  logic valid_out;
  logic [31:0] result_out;
  int cyc = 0;
  int miscompares = 0;
  int checks_done = 0;
  logic [31:0] exp_q[$];
  int due_q[$];

  sfnc_convert #(.NORM_BITS(8)) u_dut (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .valid_in(valid_in),
    .op_in(op_in),
    .round_zero_in(round_zero_in),
    .data_in(data_in),
    .valid_out(valid_out),
    .result_out(result_out)
  );

  initial begin
    forever #25 clock_in = ~clock_in;
  end

  always @(posedge clock_in) cyc <= cyc + 1;

  // ****************************************
  // Expected values
  // ****************************************
  // Binary32 of v * 2^x, v below 2^24
  function automatic logic [31:0] i2f(input logic neg, input int v, input int x);
    int p;
    logic [47:0] w;
    p = 0;
    if (v == 0) return 32'h0;
    for (int i = 0; i < 24; i++) if (v[i]) p = i;
    w = 48'(v) << (23 - p);
    return {neg, 8'(p + x + 127), w[22:0]};
  endfunction : i2f

  function automatic logic [31:0] dec(input int n, input int mb);
    int e;
    int m;
    e = n >> mb;
    m = n % (1 << mb);
    if (e == 31) return (m == 0) ? 32'h7F800000 : 32'h7FC00000;
    if (e == 0) return i2f(1'b0, m, -14 - mb);
    return i2f(1'b0, (1 << mb) + m, e - 15 - mb);
  endfunction : dec

  // ****************************************
  // Driver, monitor, verdict
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    checks_done++;
    if (got !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask : chk

  // Result due exactly two edges after the taking edge
  task automatic send(input logic [3:0] op, input logic [31:0] d, input logic rz,
                      input logic [31:0] e);
    @(posedge clock_in);
    valid_in <= 1'b1;
    op_in <= op;
    data_in <= d;
    round_zero_in <= rz;
    exp_q.push_back(e);
    due_q.push_back(cyc + 3);
    if ($urandom % 4 == 0) begin
      @(posedge clock_in);
      valid_in <= 1'b0;
      data_in <= $urandom;
    end
  endtask : send

  always @(posedge clock_in) begin
    if (valid_out !== 1'b0) begin
      if (exp_q.size() == 0) begin
        chk({31'h0, valid_out}, 32'h0);
      end else begin
        chk(result_out, exp_q.pop_front());
        chk(cyc, due_q.pop_front());
      end
    end
  end

  task automatic results();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  initial begin
    #(4000 * 50);
    miscompares++;
    results();
  end

  initial begin
    int n;
    int mb;
    int s;
    int e;
    int c;
    int v;
    logic up;
    logic rz;
    logic ng;
    logic [31:0] f;
    void'($urandom(32'h641EBF29));
    repeat (4) @(posedge clock_in);
    nrst_in <= 1'b1;
    // Special codes and clamps
    send(SFNC_OP_DEC11, 32'h7C0, 1'b0, 32'h7F800000);
    send(SFNC_OP_DEC11, 32'h7C1, 1'b0, 32'h7FC00000);
    send(SFNC_OP_DEC10, 32'h3E0, 1'b0, 32'h7F800000);
    send(SFNC_OP_DEC10, 32'h3FF, 1'b0, 32'h7FC00000);
    send(SFNC_OP_ENC11, 32'hFF800000, 1'b0, 32'h0);
    send(SFNC_OP_ENC11, 32'h7F800000, 1'b0, 32'h7C0);
    send(SFNC_OP_ENC11, 32'hFFC00001, 1'b0, 32'h7E0);
    send(SFNC_OP_ENC11, 32'hC0000000, 1'b1, 32'h0);
    send(SFNC_OP_ENC11, 32'h7F7FFFFF, 1'b0, 32'h7BF);
    send(SFNC_OP_ENC11, 32'h477FFF00, 1'b0, 32'h7BF);
    send(SFNC_OP_ENC10, 32'hFF800000, 1'b0, 32'h0);
    send(SFNC_OP_ENC10, 32'h7F800000, 1'b0, 32'h3E0);
    send(SFNC_OP_ENC10, 32'h7FC00000, 1'b0, 32'h3F0);
    send(SFNC_OP_ENC10, 32'hBF800000, 1'b0, 32'h0);
    send(SFNC_OP_ENC10, 32'h7F7FFFFF, 1'b1, 32'h3DF);
    send(SFNC_OP_UN2F, 32'h00, 1'b0, 32'h0);
    send(SFNC_OP_UN2F, 32'hFF, 1'b0, 32'h3F800000);
    send(SFNC_OP_UN2F, 32'h55, 1'b0, 32'h3EAAAAAA);
    send(SFNC_OP_UN2F, 32'h33, 1'b0, 32'h3E4CCCCC);
    send(SFNC_OP_SN2F, 32'h80, 1'b0, 32'hBF800000);
    send(SFNC_OP_SN2F, 32'h81, 1'b0, 32'hBF800000);
    send(SFNC_OP_SN2F, 32'h7F, 1'b0, 32'h3F800000);
    send(SFNC_OP_F2UN, 32'hBF000000, 1'b0, 32'h0);
    send(SFNC_OP_F2UN, 32'h40000000, 1'b0, 32'hFF);
    send(SFNC_OP_F2UN, 32'h7FC00000, 1'b0, 32'h0);
    send(SFNC_OP_F2SN, 32'hC0000000, 1'b0, 32'hFFFFFF81);
    send(SFNC_OP_F2SN, 32'h40000000, 1'b0, 32'h7F);
    send(SFNC_OP_ENC11, 32'h3F800000, 1'b0, 32'h3C0);
    send(SFNC_OP_ENC10, 32'h3F800000, 1'b1, 32'h1E0);
    send(4'hF, 32'h3F800000, 1'b0, 32'h0);
    // Decode then re-encode, with bits below the kept mantissa for normal codes
    for (int i = 0; i < 300; i++) begin
      mb = (i % 2) ? 5 : 6;
      n = $urandom % (31 << mb);
      up = $urandom;
      rz = $urandom;
      f = dec(n, mb);
      send((mb == 6) ? SFNC_OP_DEC11 : SFNC_OP_DEC10, 32'(n), rz, f);
      e = n;
      if (n >= (1 << mb)) begin
        s = 23 - mb;
        f = f | (32'(up) << (s - 1)) | ($urandom & ((32'h1 << (s - 1)) - 1));
        if (up && !rz && n + 1 != (31 << mb)) e = n + 1;
      end
      send((mb == 6) ? SFNC_OP_ENC11 : SFNC_OP_ENC10, f, rz, 32'(e));
    end
    // Normalized and fixed-point conversions
    for (int i = 0; i < 200; i++) begin
      c = $urandom % 256;
      ng = $urandom;
      v = $urandom % (1 << 24);
      send(SFNC_OP_F2UN, i2f(1'b0, c, -8), 1'b0, 32'((c * 255 + 128) >> 8));
      e = (c * 127 + 128) >> 8;
      send(SFNC_OP_F2SN, i2f(ng, c, -8), 1'b0, ng ? 32'(-e) : 32'(e));
      send(SFNC_OP_FX2F, ng ? 32'(-v) : 32'(v), 1'b0, i2f(ng, v, -16));
    end
    @(posedge clock_in);
    valid_in <= 1'b0;
    for (int i = 0; i < 20 && exp_q.size() != 0; i++) @(posedge clock_in);
    chk(32'(exp_q.size()), 32'h0);
    results();
  end

endmodule : test_small_float_norm_convert

`default_nettype wire
